//--- hw/bcrf_acc.sv
`timescale 1ns/10ps
`default_nettype none
// multiply-accumulate pair; no reset on contents
module bcrf_acc
	import bcrf_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	input  wire logic        mul_we_i,
	input  wire logic        mac_we_i,
	input  wire logic [63:0] product_i,
	input  wire logic        sys_we_i,
	input  wire bcrf_sys_t   sys_sel_i,
	input  wire logic [31:0] sys_wdata_i,
	output logic      [31:0] high_o,
	output logic      [31:0] low_o
);
	typedef struct packed {
		logic [31:0] high;
		logic [31:0] low;
	} bcrf_acc_st_t;

	bcrf_acc_st_t st_q, st_d;
	logic [63:0]  sum;

	// next value of the pair
	always_comb begin
		st_d = st_q;
		sum  = {st_q.high, st_q.low} + product_i;
		if (mac_we_i) begin
			st_d.high = sum[63:32];
			st_d.low  = sum[31:0];
		end else if (mul_we_i) begin
			st_d.high = product_i[63:32];
			st_d.low  = product_i[31:0];
		end else if (sys_we_i) begin
			if (sys_sel_i == BCRF_SYS_MUL_ACC_HIGH)
				st_d.high = sys_wdata_i;
			if (sys_sel_i == BCRF_SYS_MUL_ACC_LOW)
				st_d.low = sys_wdata_i;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		st_q <= st_d;
	end

	assign high_o = st_q.high;
	assign low_o  = st_q.low;

	chk_mac_sum_load: assert property (@(posedge sys_clk_i)
		disable iff (reset_i) mac_we_i |=>
		{high_o, low_o} == $past(sum))
		else $error("accumulate result wrong");
	chk_mul_halves: assert property (@(posedge sys_clk_i)
		disable iff (reset_i) (mul_we_i && !mac_we_i) |=>
		high_o == $past(product_i[63:32]) &&
		low_o == $past(product_i[31:0]))
		else $error("product halves misplaced");
endmodule
`default_nettype wire

//--- hw/bcrf_pkg.sv
// Behaviour
// - twenty-four 32-bit registers: two banks of eight plus eight shared
// - user mode always uses bank 0; bank 1 unreachable
// - exception entry forces bank select to 1; privileged then uses bank 1
// - privileged with bank select 0 uses bank 0; bank 1 alternate
// - unselected bank reachable only via control load/store ops
// - register zero usable implicitly as operand and as index
// - general register contents undefined after reset
// - accumulator pair and return link moved only by system load/store
// - product upper half in high accumulator, lower in low
// - multiply-accumulate adds pair contents; pair takes result
// - accumulator pair undefined after reset
// - subroutine call ops write return address to return link
// - return copies return link into instruction pointer
// - instruction pointer is current instruction address plus 4
// - no operation reads instruction pointer into a general register
// - exception entry saves instruction pointer first
// - instruction pointer supplies base for relative addressing
// - privilege bit 1 is privileged; set on reset and exception
// - bank select set to 1 on reset
package bcrf_pkg;
	localparam int unsigned BCRF_W      = 32;
	localparam int unsigned BCRF_NBANK  = 8;
	localparam logic [31:0] BCRF_IP_RST = 32'hA0000000;
	localparam logic [31:0] BCRF_IP_INC = 32'h00000004;
	localparam logic [3:0]  BCRF_R0     = 4'h0;

	// system register selector for load/store system ops
	typedef enum logic [1:0] {
		BCRF_SYS_MUL_ACC_HIGH = 2'b00,
		BCRF_SYS_MUL_ACC_LOW = 2'b01,
		BCRF_SYS_LINK = 2'b10,
		BCRF_SYS_NONE = 2'b11
	} bcrf_sys_t;

	// execute-stage command bundle
	typedef struct packed {
		logic        gr_we;
		logic [3:0]  gr_waddr;
		logic [31:0] gr_wdata;
		logic        alt_we;     // load_control_op to alternate bank
		logic [2:0]  alt_addr;
		logic [31:0] alt_wdata;
		logic        sys_we;     // load_system_op
		bcrf_sys_t   sys_sel;
		logic [31:0] sys_wdata;
		logic        mul_we;     // plain multiply
		logic        mac_we;     // multiply-accumulate
		logic [63:0] product;
		logic        call;       // any of three call ops
		logic        ret;
		logic        exc_entry;
		logic [31:0] exc_vector;
		logic        ip_load;    // taken branch / jump
		logic [31:0] ip_target;
		logic        ip_step;    // advance to next instruction
		logic        sr_we;      // control-op write of status word bits
		logic        sr_priv;
		logic        sr_bank;
	} bcrf_cmd_t;

	typedef struct packed {
		logic        priv;
		logic        bank;
		logic [31:0] ip;
		logic [31:0] saved_ip;
		logic [31:0] rd_a;
		logic [31:0] rd_b;
		logic [31:0] rd_r0;
		logic [31:0] rd_alt;
		logic [31:0] rd_sys;
	} bcrf_out_t;

	// physical low register index: bit3 is the bank
	function automatic logic [3:0] bcrf_phys(input logic priv,
		input logic bank, input logic [2:0] idx);
		bcrf_phys = {priv & bank, idx};
	endfunction
endpackage

//--- hw/bcrf_top.sv
`timescale 1ns/10ps
`default_nettype none
// banked general register file with system registers and pointer
module bcrf_top
	import bcrf_pkg::*;
(
	input  wire logic      sys_clk_i,
	input  wire logic      reset_i,
	input  wire bcrf_cmd_t cmd_i,
	input  wire logic [3:0] rd_a_addr_i,
	input  wire logic [3:0] rd_b_addr_i,
	input  wire logic [2:0] rd_alt_addr_i,
	input  wire bcrf_sys_t rd_sys_sel_i,
	output bcrf_out_t      out_o
);
	// control state; register array kept apart as it has no reset
	typedef struct packed {
		logic        priv;
		logic        bank;
		logic [31:0] ip;
		logic [31:0] saved_ip;
		logic [31:0] link;
		bcrf_out_t   out;
	} bcrf_st_t;

	bcrf_st_t    st_q, st_d;
	logic [31:0] low_q  [2*BCRF_NBANK];
	logic [31:0] high_q [BCRF_NBANK];
	logic [31:0] mul_acc_high, mul_acc_low;
	logic [3:0]  wphys, altphys, rd_altphys;
	logic        wr_low, wr_alt;

	bcrf_acc u_acc (
		.sys_clk_i   (sys_clk_i),
		.reset_i     (reset_i),
		.mul_we_i    (cmd_i.mul_we),
		.mac_we_i    (cmd_i.mac_we),
		.product_i   (cmd_i.product),
		.sys_we_i    (cmd_i.sys_we),
		.sys_sel_i   (cmd_i.sys_sel),
		.sys_wdata_i (cmd_i.sys_wdata),
		.high_o      (mul_acc_high),
		.low_o       (mul_acc_low)
	);

	// read port helper: low regs via active bank, high regs shared
	function automatic logic [31:0] rd_gr(input logic [3:0] a,
		input logic p, input logic b);
		if (a[3])
			rd_gr = high_q[a[2:0]];
		else
			rd_gr = low_q[bcrf_phys(p, b, a[2:0])];
	endfunction

	// write decode of the physical low register
	always_comb begin
		wphys   = bcrf_phys(st_q.priv, st_q.bank, cmd_i.gr_waddr[2:0]);
		wr_low  = cmd_i.gr_we && !cmd_i.gr_waddr[3];
		altphys = {~(st_q.priv & st_q.bank), cmd_i.alt_addr};
		rd_altphys = {~(st_q.priv & st_q.bank), rd_alt_addr_i};
		// alternate access exists only in privileged mode
		wr_alt  = cmd_i.alt_we && st_q.priv;
	end

	// register array; no reset, contents undefined
	always_ff @(posedge sys_clk_i) begin
		if (wr_low)
			low_q[wphys] <= cmd_i.gr_wdata;
		if (cmd_i.gr_we && cmd_i.gr_waddr[3])
			high_q[cmd_i.gr_waddr[2:0]] <= cmd_i.gr_wdata;
		// alternate write loses only to a same-cycle general write of the same physical register
		if (wr_alt && !(wr_low && wphys == altphys))
			low_q[altphys] <= cmd_i.alt_wdata;
	end

	// control state next value
	always_comb begin
		st_d = st_q;
		if (cmd_i.ip_step)
			st_d.ip = st_q.ip + BCRF_IP_INC;
		if (cmd_i.ip_load)
			st_d.ip = cmd_i.ip_target;
		if (cmd_i.call)
			st_d.link = st_q.ip;
		if (cmd_i.ret)
			st_d.ip = st_q.link;
		if (cmd_i.sys_we && cmd_i.sys_sel == BCRF_SYS_LINK &&
			!cmd_i.call)
			st_d.link = cmd_i.sys_wdata;
		// status bits writable only while privileged
		if (cmd_i.sr_we && st_q.priv) begin
			st_d.priv = cmd_i.sr_priv;
			st_d.bank = cmd_i.sr_bank;
		end
		// exception entry wins over the pointer and status writes above
		if (cmd_i.exc_entry) begin
			st_d.saved_ip = st_q.ip;
			st_d.priv = 1'b1;
			st_d.bank = 1'b1;
			st_d.ip   = cmd_i.exc_vector;
		end
		// registered outputs from next-cycle state
		st_d.out.priv     = st_d.priv;
		st_d.out.bank     = st_d.bank;
		st_d.out.ip       = st_d.ip;
		st_d.out.saved_ip = st_d.saved_ip;
		// pointer has no general read path
		st_d.out.rd_a   = rd_gr(rd_a_addr_i, st_q.priv, st_q.bank);
		st_d.out.rd_b   = rd_gr(rd_b_addr_i, st_q.priv, st_q.bank);
		st_d.out.rd_r0  = rd_gr(BCRF_R0, st_q.priv, st_q.bank);
		st_d.out.rd_alt = st_q.priv ? low_q[rd_altphys] : '0;
		case (rd_sys_sel_i)
			BCRF_SYS_MUL_ACC_HIGH: st_d.out.rd_sys = mul_acc_high;
			BCRF_SYS_MUL_ACC_LOW: st_d.out.rd_sys = mul_acc_low;
			BCRF_SYS_LINK: st_d.out.rd_sys = st_q.link;
			default:       st_d.out.rd_sys = '0;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_q          <= '0;
			st_q.priv     <= 1'b1;
			st_q.bank     <= 1'b1;
			st_q.ip       <= BCRF_IP_RST;
			st_q.out.priv <= 1'b1;
			st_q.out.bank <= 1'b1;
			st_q.out.ip   <= BCRF_IP_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign out_o = st_q.out;

	chk_reset_state: assert property (@(posedge sys_clk_i)
		$past(reset_i) |-> out_o.priv && out_o.bank &&
		out_o.ip == BCRF_IP_RST)
		else $error("reset state wrong");
	chk_exc_bank_set: assert property (@(posedge sys_clk_i)
		disable iff (reset_i) cmd_i.exc_entry |=>
		out_o.bank && out_o.priv)
		else $error("exception did not select bank 1");
	chk_exc_save_ip: assert property (@(posedge sys_clk_i)
		disable iff (reset_i) cmd_i.exc_entry |=>
		out_o.saved_ip == $past(st_q.ip))
		else $error("pointer not saved");
	chk_call_link: assert property (@(posedge sys_clk_i)
		disable iff (reset_i) (cmd_i.call && !cmd_i.exc_entry) ##1
		(cmd_i.ret && !cmd_i.exc_entry) |=>
		out_o.ip == $past(st_q.ip, 2))
		else $error("return address wrong");
	chk_ip_step: assert property (@(posedge sys_clk_i)
		disable iff (reset_i) (cmd_i.ip_step && !cmd_i.ip_load &&
		!cmd_i.ret && !cmd_i.exc_entry) |=>
		out_o.ip == $past(st_q.ip) + BCRF_IP_INC)
		else $error("pointer step not 4");
	chk_user_bank0: assert property (@(posedge sys_clk_i)
		disable iff (reset_i) (wr_low && !st_q.priv) |->
		!wphys[3])
		else $error("user write reached bank 1");
	chk_alt_other: assert property (@(posedge sys_clk_i)
		disable iff (reset_i) wr_alt |->
		altphys[3] != wphys[3])
		else $error("alternate hit active bank");
	chk_priv_bank0: assert property (@(posedge sys_clk_i)
		disable iff (reset_i) (wr_low && st_q.priv && !st_q.bank)
		|-> !wphys[3])
		else $error("bank 0 not used");
	chk_gr_rdback: assert property (@(posedge sys_clk_i)
		disable iff (reset_i) (cmd_i.gr_we && !cmd_i.sr_we &&
		!cmd_i.exc_entry && !cmd_i.alt_we) ##1
		(rd_a_addr_i == $past(cmd_i.gr_waddr)) |=>
		out_o.rd_a == $past(cmd_i.gr_wdata, 2))
		else $error("read after write mismatch");

	cov_exc: cover property (@(posedge sys_clk_i) cmd_i.exc_entry);
	cov_call_ret: cover property (@(posedge sys_clk_i)
		cmd_i.call ##[1:4] cmd_i.ret);
	cov_user: cover property (@(posedge sys_clk_i) !st_q.priv);
	cov_alt: cover property (@(posedge sys_clk_i) wr_alt);
endmodule
`default_nettype wire

//--- tb/bcrf_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// core pipeline stand-in: one command per edge, optional bubbles
module bcrf_core_model
	import bcrf_pkg::*;
(
	input  wire logic       sys_clk_i,
	output bcrf_cmd_t       cmd_o,
	output logic      [3:0] ra_o,
	output logic      [3:0] rb_o,
	output logic      [2:0] ralt_o,
	output bcrf_sys_t       rsys_o
);
	initial begin
		cmd_o = '0;
		ra_o = 4'h0;
		rb_o = 4'h0;
		ralt_o = 3'h0;
		rsys_o = BCRF_SYS_NONE;
	end

	// bubbles clear every strobe so a slow core never repeats a write
	task automatic issue(input bcrf_cmd_t c, input logic [3:0] a,
		input logic [3:0] b, input logic [2:0] x, input bcrf_sys_t s,
		input int idle);
		repeat (idle) begin
			@(posedge sys_clk_i);
			cmd_o <= '0;
		end
		@(posedge sys_clk_i);
		cmd_o <= c;
		ra_o <= a;
		rb_o <= b;
		ralt_o <= x;
		rsys_o <= s;
	endtask
endmodule
`default_nettype wire

//--- tb/test_banked_cpu_register_file.sv
`timescale 1ns/10ps
`default_nettype none
module test_banked_cpu_register_file;
	import bcrf_pkg::*;
	typedef struct {int due; int f; logic [31:0] v;} bcrf_note_t;
	logic        sys_clk_i;
	logic        reset_i;
	bcrf_cmd_t   cmd, c;
	logic [3:0]  ra, rb;
	logic [2:0]  ralt;
	bcrf_sys_t   rsys;
	bcrf_out_t   out;
	bcrf_note_t  q[$], n;
	int          mismatches, total_checks, cyc, last;
	logic [31:0] seed, got, d0, d1, d2, eip, esav, elink;
	logic [63:0] acc, p;
	logic        epriv, ebank;

	bcrf_top bcrf_top_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.cmd_i(cmd), .rd_a_addr_i(ra), .rd_b_addr_i(rb),
		.rd_alt_addr_i(ralt), .rd_sys_sel_i(rsys), .out_o(out));
	bcrf_core_model bcrf_core_model_i (.sys_clk_i(sys_clk_i), .cmd_o(cmd),
		.ra_o(ra), .rb_o(rb), .ralt_o(ralt), .rsys_o(rsys));

	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) cyc <= cyc + 1;

	function automatic logic [31:0] pick(input int f);
		case (f)
			0: pick = out.rd_a;
			1: pick = out.rd_b;
			2: pick = out.rd_r0;
			3: pick = out.rd_alt;
			4: pick = out.rd_sys;
			5: pick = out.ip;
			6: pick = out.saved_ip;
			default: pick = {30'h0, out.priv, out.bank};
		endcase
	endfunction

	// results are registered, so notes fall due two edges after drive
	task automatic chk(input int f, input logic [31:0] v);
		q.push_back('{last + 2, f, v});
	endtask

	// drive one command and track pointer, link and mode alongside
	task automatic step(input logic [3:0] a, input logic [2:0] x,
		input bcrf_sys_t s, input int idle);
		bcrf_core_model_i.issue(c, a, 4'h9, x, s, idle);
		last = cyc;
		if (c.sys_we && c.sys_sel == BCRF_SYS_LINK) elink = c.sys_wdata;
		if (c.call) elink = eip;
		if (c.exc_entry) begin
			esav = eip;
			eip = c.exc_vector;
			{epriv, ebank} = 2'h3;
		end else begin
			if (c.ret) eip = elink;
			else if (c.ip_load) eip = c.ip_target;
			else if (c.ip_step) eip = eip + BCRF_IP_INC;
			if (c.sr_we && epriv) {epriv, ebank} = {c.sr_priv, c.sr_bank};
		end
		chk(5, eip);
		chk(6, esav);
		chk(7, {30'h0, epriv, ebank});
		c = '0;
	endtask

	task automatic fin(input string s);
		$display("done %s", s);
	endtask

	task automatic complete_run;
		if (q.size() != 0) mismatches++;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// monitor takes the oldest notes as their results appear
	always @(negedge sys_clk_i) begin
		while (q.size() > 0 && q[0].due <= cyc) begin
			n = q.pop_front();
			got = pick(n.f);
			total_checks++;
			if (got !== n.v || n.due != cyc) begin
				mismatches++;
				$display("BAD t=%0t got %h exp %h", $time, got, n.v);
			end
		end
	end

	initial begin
		#20000;
		mismatches++;
		complete_run();
	end

	initial begin
		{seed, mismatches, total_checks, cyc} = {32'hEDAC, 96'h0};
		// fields set apart: a packed concatenation here would drop the top bits
		eip = BCRF_IP_RST;
		{esav, epriv, ebank} = {32'h0, 2'h3};
		c = '0;
		reset_i = 1'b1;
		repeat (3) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		step(4'h0, 3'h0, BCRF_SYS_NONE, 0);
		fin("reset");
		d0 = $random(seed);
		d1 = $random(seed);
		d2 = $random(seed);
		{c.gr_we, c.gr_waddr, c.gr_wdata} = {5'h13, d1};
		{c.alt_we, c.alt_addr, c.alt_wdata} = {4'hB, d0};
		step(4'h0, 3'h0, BCRF_SYS_NONE, 0);
		{c.gr_we, c.gr_waddr, c.gr_wdata} = {5'h19, d2};
		step(4'h3, 3'h3, BCRF_SYS_NONE, 0);
		chk(0, d1);
		chk(3, d0);
		{c.sr_we, c.sr_priv, c.sr_bank} = 3'h6;
		step(4'h3, 3'h3, BCRF_SYS_NONE, 1);
		chk(1, d2);
		{c.sr_we, c.sr_priv, c.sr_bank} = 3'h5;
		step(4'h3, 3'h3, BCRF_SYS_NONE, 0);
		chk(0, d0);
		chk(3, d1);
		{c.alt_we, c.alt_addr, c.alt_wdata} = {4'hB, d2};
		{c.sr_we, c.sr_priv, c.sr_bank} = 3'h7;
		step(4'h3, 3'h3, BCRF_SYS_NONE, 0);
		chk(0, d0);
		chk(3, 32'h0);
		{c.exc_entry, c.exc_vector, c.ip_step} = {1'b1, d2 & ~32'h3, 1'b1};
		step(4'h0, 3'h0, BCRF_SYS_NONE, 0);
		step(4'h3, 3'h3, BCRF_SYS_NONE, 0);
		chk(0, d1);
		chk(3, d0);
		fin("banks");
		{c.gr_we, c.gr_waddr, c.gr_wdata} = {5'h10, d2};
		step(4'h0, 3'h0, BCRF_SYS_NONE, 0);
		step(4'h0, 3'h0, BCRF_SYS_NONE, 0);
		chk(2, d2);
		fin("zero");
		acc = {$random(seed), $random(seed)};
		p = {$random(seed), $random(seed)};
		{c.sys_we, c.sys_sel, c.sys_wdata} = {1'b1, BCRF_SYS_MUL_ACC_HIGH, acc[63:32]};
		step(4'h0, 3'h0, BCRF_SYS_NONE, 0);
		{c.sys_we, c.sys_sel, c.sys_wdata} = {1'b1, BCRF_SYS_MUL_ACC_LOW, acc[31:0]};
		step(4'h0, 3'h0, BCRF_SYS_MUL_ACC_HIGH, 0);
		chk(4, acc[63:32]);
		{c.mac_we, c.product} = {1'b1, p};
		step(4'h0, 3'h0, BCRF_SYS_MUL_ACC_LOW, 0);
		chk(4, acc[31:0]);
		acc = acc + p;
		step(4'h0, 3'h0, BCRF_SYS_MUL_ACC_HIGH, 0);
		chk(4, acc[63:32]);
		{c.mul_we, c.product} = {1'b1, ~p};
		step(4'h0, 3'h0, BCRF_SYS_MUL_ACC_LOW, 0);
		chk(4, acc[31:0]);
		step(4'h0, 3'h0, BCRF_SYS_MUL_ACC_HIGH, 0);
		chk(4, ~p[63:32]);
		step(4'h0, 3'h0, BCRF_SYS_MUL_ACC_LOW, 0);
		chk(4, ~p[31:0]);
		fin("acc");
		c.ip_step = 1'b1;
		step(4'h0, 3'h0, BCRF_SYS_NONE, 2);
		{c.call, c.ip_load, c.ip_target} = {2'h3, d0 & ~32'h3};
		step(4'h0, 3'h0, BCRF_SYS_NONE, 0);
		c.ret = 1'b1;
		step(4'h0, 3'h0, BCRF_SYS_LINK, 0);
		chk(4, elink);
		{c.sys_we, c.sys_sel, c.sys_wdata} = {1'b1, BCRF_SYS_LINK, d1};
		step(4'h0, 3'h0, BCRF_SYS_NONE, 0);
		c.ret = 1'b1;
		step(4'h0, 3'h0, BCRF_SYS_NONE, 0);
		fin("link");
		repeat (4) @(posedge sys_clk_i);
		complete_run();
	end
endmodule
`default_nettype wire
